// [rtl/mfc2_pkg.sv]
// shared constants, types and register map of the fault configuration block
package mfc2_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  // register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h44;
  localparam logic [7:0] OFS_CTRL = 8'h80;
  localparam logic [7:0] OFS_STAT = 8'h84;
  localparam logic [7:0] OFS_MASK = 8'h88;
  localparam logic [7:0] OFS_FAULT = 8'h8C;
  // reset values and writable bits
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_WMASK = 32'h07FF_E0FF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // configuration field positions
  localparam int CFG_OVS_EN = 26;
  localparam int CFG_EMF_EN = 25;
  localparam int CFG_ABS_EN = 24;
  localparam int CFG_OVS_LSB = 21;
  localparam int CFG_EMF_LSB = 18;
  localparam int CFG_ABS_LSB = 13;
  localparam int CFG_LOW_LSB = 5;
  localparam int CFG_LOW_AUTO = 4;
  localparam int CFG_HIGH_LSB = 1;
  localparam int CFG_HIGH_AUTO = 0;
  // event and fault bit positions
  localparam int EV_OVS = 0;
  localparam int EV_EMF = 1;
  localparam int EV_ABS = 2;
  localparam int EV_LOW = 3;
  localparam int EV_HIGH = 4;
  localparam int EV_W = 5;
  localparam int FLT_LOCK = 0;
  localparam int FLT_LOW = 1;
  localparam int FLT_HIGH = 2;
  localparam int FLT_W = 3;
  localparam int CTRL_MODE_LSB = 0;
  // thresholds in per mille of the relevant base
  localparam int PM_W = 12;
  localparam logic [11:0] SPD_BASE = 12'd1300;
  localparam logic [11:0] SPD_STEP = 12'd100;
  localparam logic [11:0] EMF_BASE = 12'd100;
  localparam logic [11:0] EMF_STEP = 12'd100;
  localparam logic [11:0] HIGH_BASE = 12'd600;
  localparam logic [11:0] HIGH_STEP = 12'd50;
  localparam logic [2:0] HIGH_NOLIM = 3'd7;
  localparam logic [2:0] LOW_NOLIM = 3'd0;
  // timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RETRY_TIME_MS = 100;
  // stall response modes in code order
  typedef enum logic [1:0] {
    MODE_LATCH,
    MODE_RETRY,
    MODE_REPORT,
    MODE_OFF
  } mfc2_mode_t;
  // measured quantities, per mille of their bases
  typedef struct packed {
    logic [11:0] speed;
    logic [11:0] emf_dev;
    logic [11:0] current;
    logic [11:0] supply;
    logic drive_active;
  } mfc2_sense_t;
  // avalon request bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } mfc2_avm_req_t;
endpackage : mfc2_pkg

// [rtl/mfc2_top.sv]
// fault detection configuration register with lock and supply fault logic
// What this block does
// - config word at 0x44, 32 bits, resets to zero, read and write
// - bit 26 enables the overspeed lock check
// - bit 25 enables the back-emf deviation lock check
// - bit 24 enables the absent-motor lock check
// - bits 23:21 pick overspeed limit, 130 to 200 percent, 10 percent steps
// - bits 20:18 pick back-emf limit, 10 to 80 percent, 10 percent steps
// - bits 17:13 pick absent-motor current limit from a nonlinear table
// - bits 7:5 pick supply low limit, code zero means none
// - bit 4 chooses latched or self-clearing under-voltage fault
// - bits 3:1 pick supply high limit, 60 to 90 percent, code 7 none
// - bit 0 chooses latched or self-clearing over-voltage fault
// - tripped lock check answers per mode: latch, retry, report, off
`timescale 1ns/1ns
module mfc2_top #(
  parameter int unsigned RETRY_CYCLES =
    mfc2_pkg::CLK_HZ / 1000 * mfc2_pkg::RETRY_TIME_MS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire mfc2_pkg::mfc2_avm_req_t avm_req,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  input wire mfc2_pkg::mfc2_sense_t sense,
  output logic fault_output_n,
  output logic irq
);
  import mfc2_pkg::*;

  // refuse a retry time the counter cannot hold
  if (RETRY_CYCLES < 1 || RETRY_CYCLES > 32'h00FF_FFFF) begin : g_chk
    $error("retry cycles out of range");
  end

  // refuse limit steps that overflow the 12-bit sense scale
  if (int'(SPD_BASE) + 7 * int'(SPD_STEP) > 32'h0000_0FFF) begin : g_spd_chk
    $error("overspeed limit overflows the sense scale");
  end
  if (int'(EMF_BASE) + 7 * int'(EMF_STEP) > 32'h0000_0FFF) begin : g_emf_chk
    $error("emf limit overflows the sense scale");
  end
  if (int'(HIGH_BASE) + 6 * int'(HIGH_STEP) > 32'h0000_0FFF) begin : g_high_chk
    $error("supply high limit overflows the sense scale");
  end

  // refuse a write mask that would open the reserved bits
  if (CFG_WMASK[31:27] != 5'h0 || CFG_WMASK[12:8] != 5'h0) begin : g_rsv_chk
    $error("reserved config bits must stay read-only");
  end

  // overspeed limit in per mille of full speed
  function automatic logic [11:0] spd_limit(input logic [2:0] code);
    spd_limit = SPD_BASE + 12'(code) * SPD_STEP;
  endfunction : spd_limit

  // back-emf deviation limit in per mille of expected
  function automatic logic [11:0] emf_limit(input logic [2:0] code);
    emf_limit = EMF_BASE + 12'(code) * EMF_STEP;
  endfunction : emf_limit

  // supply high limit; code 7 means no limit
  function automatic logic [11:0] high_limit(input logic [2:0] code);
    high_limit = HIGH_BASE + 12'(code) * HIGH_STEP;
  endfunction : high_limit

  // supply low limit, per mille of base voltage
  function automatic logic [11:0] low_limit(input logic [2:0] code);
    case (code)
      3'd1: low_limit = 12'd50;
      3'd2: low_limit = 12'd100;
      3'd3: low_limit = 12'd120;
      3'd4: low_limit = 12'd150;
      3'd5: low_limit = 12'd180;
      3'd6: low_limit = 12'd200;
      3'd7: low_limit = 12'd250;
      default: low_limit = 12'd0;
    endcase
  endfunction : low_limit

  // absent-motor current limit, per mille of base current
  function automatic logic [11:0] abs_limit(input logic [4:0] code);
    case (code)
      5'h00: abs_limit = 12'd75;
      5'h01: abs_limit = 12'd80;
      5'h02: abs_limit = 12'd85;
      5'h03: abs_limit = 12'd90;
      5'h04: abs_limit = 12'd95;
      5'h05: abs_limit = 12'd100;
      5'h06: abs_limit = 12'd110;
      5'h07: abs_limit = 12'd120;
      5'h08: abs_limit = 12'd130;
      5'h09: abs_limit = 12'd140;
      5'h0A: abs_limit = 12'd150;
      5'h0B: abs_limit = 12'd160;
      5'h0C: abs_limit = 12'd170;
      5'h0D: abs_limit = 12'd180;
      5'h0E: abs_limit = 12'd200;
      5'h0F: abs_limit = 12'd225;
      5'h10: abs_limit = 12'd250;
      5'h11: abs_limit = 12'd275;
      5'h12: abs_limit = 12'd300;
      5'h13: abs_limit = 12'd350;
      5'h14: abs_limit = 12'd400;
      5'h15: abs_limit = 12'd450;
      5'h16: abs_limit = 12'd500;
      5'h17: abs_limit = 12'd550;
      5'h18: abs_limit = 12'd600;
      5'h19: abs_limit = 12'd700;
      5'h1A: abs_limit = 12'd750;
      5'h1B: abs_limit = 12'd800;
      5'h1C: abs_limit = 12'd850;
      5'h1D: abs_limit = 12'd900;
      5'h1E: abs_limit = 12'd950;
      default: abs_limit = 12'd1000;
    endcase
  endfunction : abs_limit

  // merge a write under byte enables
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old_v & ~m) | (new_v & m);
  endfunction : be_merge

  // supply fault next state: a trip sets and beats any clear
  function automatic logic supply_next(
    input logic cur,
    input logic trip,
    input logic auto_clr,
    input logic sw_clr
  );
    if (trip) begin
      supply_next = 1'b1;
    end else if (auto_clr || sw_clr) begin
      supply_next = 1'b0;
    end else begin
      supply_next = cur;
    end
  endfunction : supply_next

  // registers
  logic [31:0] cfg_q, cfg_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [EV_W-1:0] stat_q, stat_d;
  logic [EV_W-1:0] mask_q, mask_d;
  logic [FLT_W-1:0] fault_q, fault_d;
  logic [EV_W-1:0] trip_q;
  logic [23:0] retry_q, retry_d;
  logic ack_q;
  logic [31:0] rdata_q;
  logic fault_n_q;
  logic irq_q;

  // configuration fields
  wire logic ovs_en = cfg_q[CFG_OVS_EN];
  wire logic emf_en = cfg_q[CFG_EMF_EN];
  wire logic abs_en = cfg_q[CFG_ABS_EN];
  wire logic [2:0] ovs_sel = cfg_q[CFG_OVS_LSB +: 3];
  wire logic [2:0] emf_sel = cfg_q[CFG_EMF_LSB +: 3];
  wire logic [4:0] abs_sel = cfg_q[CFG_ABS_LSB +: 5];
  wire logic [2:0] low_sel = cfg_q[CFG_LOW_LSB +: 3];
  wire logic low_auto = cfg_q[CFG_LOW_AUTO];
  wire logic [2:0] high_sel = cfg_q[CFG_HIGH_LSB +: 3];
  wire logic high_auto = cfg_q[CFG_HIGH_AUTO];
  wire mfc2_mode_t mode = mfc2_mode_t'(ctrl_q);

  // lock checks against the selected limits
  wire logic ovs_trip = ovs_en && (sense.speed > spd_limit(ovs_sel));
  wire logic emf_trip = emf_en && (sense.emf_dev > emf_limit(emf_sel));
  wire logic abs_trip = abs_en && sense.drive_active
    && (sense.current < abs_limit(abs_sel));
  wire logic lock_live = (mode != MODE_OFF);
  wire logic lock_faults = (mode == MODE_LATCH) || (mode == MODE_RETRY);
  wire logic retry_done = (retry_q <= 24'd1); // retry delay used up

  // supply checks, code 0 low and code 7 high mean no limit
  wire logic low_trip = (low_sel != LOW_NOLIM)
    && (sense.supply < low_limit(low_sel));
  wire logic high_trip = (high_sel != HIGH_NOLIM)
    && (sense.supply > high_limit(high_sel));

  // trip vector and its rising edges
  wire logic [EV_W-1:0] trip_v = {
    high_trip,
    low_trip,
    abs_trip && lock_live,
    emf_trip && lock_live,
    ovs_trip && lock_live
  };
  wire logic [EV_W-1:0] ev_rise = trip_v & ~trip_q;
  wire logic lock_trip = |trip_v[EV_ABS:EV_OVS];

  // bus decode
  wire logic req = avm_req.read || avm_req.write;
  wire logic [7:0] adr = avm_req.address;
  wire logic sel_cfg = (adr == OFS_CFG);
  wire logic sel_ctrl = (adr == OFS_CTRL);
  wire logic sel_stat = (adr == OFS_STAT);
  wire logic sel_mask = (adr == OFS_MASK);
  wire logic sel_fault = (adr == OFS_FAULT);
  wire logic wr_ack = ack_q && avm_req.write;
  wire logic rd_ack = ack_q && avm_req.read;
  wire logic [31:0] wmerge_cfg = be_merge(cfg_q, avm_req.writedata, avm_req.byteenable);
  wire logic [31:0] wdat = avm_req.writedata;
  // write strobes per register, the small registers need lane 0
  wire logic wr_cfg = wr_ack && sel_cfg;
  wire logic wr_ctrl = wr_ack && sel_ctrl && avm_req.byteenable[0];
  wire logic wr_mask = wr_ack && sel_mask && avm_req.byteenable[0];
  wire logic wr_fault = wr_ack && sel_fault && avm_req.byteenable[0];
  wire logic [FLT_W-1:0] w1c = wr_fault
    ? wdat[FLT_W-1:0] : '0;
  wire logic [EV_W-1:0] rd_clr = (rd_ack && sel_stat) ? rdata_q[EV_W-1:0] : '0;

  // read mux, unmapped reads return zero
  logic [31:0] rmux;
  always_comb begin
    rmux = ZERO_WORD;
    if (sel_cfg) begin
      rmux = cfg_q;
    end else if (sel_ctrl) begin
      rmux = {30'd0, ctrl_q};
    end else if (sel_stat) begin
      rmux = {27'd0, stat_q};
    end else if (sel_mask) begin
      rmux = {27'd0, mask_q};
    end else if (sel_fault) begin
      rmux = {29'd0, fault_q};
    end
  end

  // register writes take effect at the accepting edge
  always_comb begin
    cfg_d = cfg_q;
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    if (wr_cfg) begin
      cfg_d = wmerge_cfg & CFG_WMASK;
    end
    if (wr_ctrl) begin
      ctrl_d = wdat[CTRL_MODE_LSB +: 2];
    end
    if (wr_mask) begin
      mask_d = wdat[EV_W-1:0];
    end
  end

  // sticky status, a read clears only bits it returned, set wins
  assign stat_d = (stat_q & ~rd_clr) | ev_rise;

  // fault state, a new trip beats any clear
  always_comb begin
    fault_d = fault_q;
    retry_d = retry_q;
    // lock fault: latch or retry, report and off raise none
    if (lock_trip && lock_faults) begin
      fault_d[FLT_LOCK] = 1'b1;
      retry_d = 24'(RETRY_CYCLES);
    end else if (fault_q[FLT_LOCK]) begin
      if (w1c[FLT_LOCK]) begin
        fault_d[FLT_LOCK] = 1'b0;
      end else if (mode == MODE_RETRY) begin
        if (retry_done) begin
          fault_d[FLT_LOCK] = 1'b0;
        end else begin
          retry_d = retry_q - 24'd1;
        end
      end else if (mode != MODE_LATCH) begin
        fault_d[FLT_LOCK] = 1'b0;
      end
    end
    // under-voltage then over-voltage, latched or self-clearing
    fault_d[FLT_LOW] = supply_next(fault_q[FLT_LOW], low_trip, low_auto,
      w1c[FLT_LOW]);
    fault_d[FLT_HIGH] = supply_next(fault_q[FLT_HIGH], high_trip, high_auto,
      w1c[FLT_HIGH]);
  end

  // config and control storage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_q <= CFG_RESET;
      ctrl_q <= 2'd0;
      mask_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
    end
  end

  // event and fault storage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stat_q <= '0;
      trip_q <= '0;
      fault_q <= '0;
      retry_q <= '0;
    end else begin
      stat_q <= stat_d;
      trip_q <= trip_v;
      fault_q <= fault_d;
      retry_q <= retry_d;
    end
  end

  // bus handshake: capture on first cycle, answer on second
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdata_q <= ZERO_WORD;
    end else begin
      ack_q <= req && !ack_q;
      if (avm_req.read && !ack_q) begin
        rdata_q <= rmux;
      end
    end
  end

  // fault pin and interrupt registered from next-state values
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fault_n_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      fault_n_q <= ~(|fault_d);
      irq_q <= |(stat_d & mask_d);
    end
  end

  // outputs
  assign avm_waitrequest = req && !ack_q;
  assign avm_readdata = rdata_q;
  assign fault_output_n = fault_n_q;
  assign irq = irq_q;
endmodule : mfc2_top

// [tb/mfc2_drive_model.sv]
// drive stage model presenting measured speed, emf, current and supply
`timescale 1ns/1ns
module mfc2_drive_model (
  input logic clk_sys,
  input mfc2_pkg::mfc2_sense_t cmd,
  output mfc2_pkg::mfc2_sense_t sense
);
  import mfc2_pkg::*;
  // sense values follow the commanded operating point one edge later
  initial sense = '0;
  always @(posedge clk_sys) sense <= cmd;
endmodule : mfc2_drive_model

// [tb/mfc2_sva.sv]
// concurrent checks on the ports of the fault configuration block
`timescale 1ns/1ns
module mfc2_sva #(
  parameter int unsigned RETRY_CYCLES = 20
) (
  input logic clk_sys,
  input logic reset,
  input mfc2_pkg::mfc2_avm_req_t avm_req,
  input logic [31:0] avm_readdata,
  input logic avm_waitrequest,
  input mfc2_pkg::mfc2_sense_t sense,
  input logic fault_output_n,
  input logic irq
);
  import mfc2_pkg::*;
  localparam logic [11:0] LOW_LIM [8] = '{0, 50, 100, 120, 150, 180, 200, 250};
  logic [31:0] cfg_q;
  logic [1:0] mode_q;
  logic [31:0] wm;
  logic acc, ovs_t, emf_t, low_t, high_t;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // shadow of config and stall mode as accepted on the bus
  assign acc = avm_req.write && !avm_waitrequest;
  assign wm = 32'h07FF_E0FF & {{8{avm_req.byteenable[3]}}, {8{avm_req.byteenable[2]}},
    {8{avm_req.byteenable[1]}}, {8{avm_req.byteenable[0]}}};
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_q <= 32'h0000_0000;
      mode_q <= 2'h0;
    end else if (acc && avm_req.address == OFS_CFG) begin
      cfg_q <= (cfg_q & ~wm) | (avm_req.writedata & wm);
    end else if (acc && avm_req.address == OFS_CTRL && avm_req.byteenable[0]) begin
      mode_q <= avm_req.writedata[1:0];
    end
  end
  // trip conditions from sense and the shadow config
  assign ovs_t = cfg_q[26] && sense.speed > 12'd1300 + 12'd100 * cfg_q[23:21];
  assign emf_t = cfg_q[25] && sense.emf_dev > 12'd100 + 12'd100 * cfg_q[20:18];
  assign low_t = cfg_q[7:5] != 3'h0 && sense.supply < LOW_LIM[cfg_q[7:5]];
  assign high_t = cfg_q[3:1] != 3'h7 && sense.supply > 12'd600 + 12'd50 * cfg_q[3:1];
  wait_one_a: assert property ((avm_req.read || avm_req.write) && avm_waitrequest
    |=> !avm_waitrequest) else $error("waitrequest held too long");
  cfg_readback_a: assert property (avm_req.read && !avm_waitrequest
    && avm_req.address == OFS_CFG |-> avm_readdata == cfg_q) else $error("config readback");
  unmapped_zero_a: assert property (avm_req.read && !avm_waitrequest
    && avm_req.address == 8'h40 |-> avm_readdata == 32'h0000_0000) else $error("unmapped read");
  overspeed_fault_a: assert property ($rose(ovs_t) && !mode_q[1]
    |=> !fault_output_n) else $error("overspeed fault missing");
  emf_fault_a: assert property ($rose(emf_t) && !mode_q[1]
    |=> !fault_output_n) else $error("emf fault missing");
  low_fault_a: assert property ($rose(low_t) |=> !fault_output_n)
    else $error("under-voltage fault missing");
  high_fault_a: assert property ($rose(high_t) |=> !fault_output_n)
    else $error("over-voltage fault missing");
  quiet_a: assert property (fault_output_n && !cfg_q[24] && !low_t && !high_t
    && !((ovs_t || emf_t) && !mode_q[1]) |=> fault_output_n) else $error("spurious fault");
  cover property ($rose(low_t));
  cover property ($rose(high_t));
  cover property ($rose(ovs_t) && mode_q == 2'h2);
endmodule : mfc2_sva

// [tb/tb_top.sv]
// self-checking bench for the fault configuration block
`timescale 1ns/1ns
module tb_top;
  import mfc2_pkg::*;
  localparam int unsigned RC = 20;
  localparam logic [11:0] ABS_LIM [32] = '{75, 80, 85, 90, 95, 100, 110, 120, 130, 140, 150,
    160, 170, 180, 200, 225, 250, 275, 300, 350, 400, 450, 500, 550, 600, 700, 750, 800, 850,
    900, 950, 1000};
  localparam logic [11:0] LOW_LIM [8] = '{0, 50, 100, 120, 150, 180, 200, 250};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  mfc2_avm_req_t avm_req = '0;
  mfc2_sense_t cmd = '{12'd0, 12'd0, 12'd1000, 12'd500, 1'b1};
  mfc2_sense_t sense;
  logic [31:0] avm_readdata, q, d, cfg;
  logic [3:0] b;
  logic avm_waitrequest, fault_output_n, irq;
  int errors = 0;
  int n_checks = 0;
  mfc2_top #(.RETRY_CYCLES(RC)) i_mfc2_top (.*);
  mfc2_drive_model i_mfc2_drive_model (.*);
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // verdict and end of run
  task automatic tally_and_finish;
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    input logic [3:0] be);
    int n = 0;
    avm_req <= '{!w, w, a, wd, be};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avm_waitrequest !== 1'b0 && n < 50);
    q = avm_readdata;
    avm_req.read <= 1'b0;
    avm_req.write <= 1'b0;
    @(posedge clk_sys);
    if (n >= 50) begin
      errors++;
      tally_and_finish();
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(q, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, 4'hF);
  endtask : wr
  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & 32'h07FF_E0FF;
  endfunction : lanes
  task automatic setq(input int k, input logic [11:0] v);
    case (k)
      0: cmd.speed <= v;
      1: cmd.emf_dev <= v;
      2: cmd.current <= v;
      default: cmd.supply <= v;
    endcase
  endtask : setq
  // hold a quantity at its limit, step past it, then return and clear
  task automatic probe(input int k, input logic [31:0] c, input logic [11:0] lim,
    input logic en, input logic au);
    logic mk;
    mk = 1'($urandom);
    wr(OFS_MASK, {27'h0, {5{mk}}});
    wr(OFS_CFG, c);
    setq(k, lim);
    tick(3);
    chk(fault_output_n, 1'b1);
    setq(k, (k == 2 || k == 3) ? lim - 12'd1 : lim + 12'd1);
    tick(3);
    chk(fault_output_n, !en);
    chk(irq, en & mk);
    rd(OFS_FAULT, 32'(en) << (k < 3 ? 0 : k - 2));
    rd(OFS_STAT, 32'(en) << k);
    setq(k, lim);
    tick(3);
    chk(fault_output_n, !en | au);
    wr(OFS_FAULT, 32'h0000_0007);
    tick(2);
    chk(fault_output_n, 1'b1);
    chk(irq, 1'b0);
    rd(OFS_STAT, 32'h0000_0000);
  endtask : probe
  initial begin
    void'($urandom(45691));
    cfg = 32'h0000_0000;
    tick(4);
    reset <= 1'b0;
    tick(1);
    rd(OFS_CFG, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      b = 4'($urandom);
      bus(1'b1, OFS_CFG, d, b);
      cfg = (cfg & ~lanes(b)) | (d & lanes(b));
      rd(OFS_CFG, cfg);
    end
    // small registers ignore a write without lane 0
    bus(1'b1, OFS_CTRL, 32'h0000_0003, 4'hE);
    rd(OFS_CTRL, 32'h0000_0000);
    for (int c = 0; c < 8; c++) begin
      probe(0, 32'h0400_0000 | 32'(c) << 21, 12'(1300 + 100 * c), 1'b1, 1'b0);
      probe(1, 32'h0200_0000 | 32'(c) << 18, 12'(100 + 100 * c), 1'b1, 1'b0);
    end
    for (int c = 31; c >= 0; c--) probe(2, 32'h0100_0000 | 32'(c) << 13, ABS_LIM[c], 1, 0);
    // absent-motor check only while driving; a clear loses to a standing trip
    cmd.drive_active <= 1'b0;
    wr(OFS_CFG, 32'h0100_0000);
    setq(2, 12'd0);
    tick(3);
    chk(fault_output_n, 1'b1);
    cmd.drive_active <= 1'b1;
    tick(3);
    chk(fault_output_n, 1'b0);
    wr(OFS_FAULT, 32'h0000_0007);
    rd(OFS_FAULT, 32'h0000_0001);
    rd(OFS_STAT, 32'h0000_0004);
    setq(2, 12'd75);
    wr(OFS_FAULT, 32'h0000_0007);
    rd(OFS_FAULT, 32'h0000_0000);
    for (int k = 0; k < 3; k++) probe(k, $urandom & 32'h00FF_E0E0, 12'd100, 0, 0);
    setq(0, 12'd1300);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CTRL, 32'(m));
      wr(OFS_CFG, 32'h0400_0000);
      setq(0, 12'd1301);
      tick(3);
      chk(fault_output_n, m > 1);
      rd(OFS_STAT, 32'(m != 3));
      setq(0, 12'd1300);
      tick(RC / 2);
      chk(fault_output_n, m > 1);
      tick(RC);
      chk(fault_output_n, m != 0);
      wr(OFS_FAULT, 32'h0000_0007);
      tick(2);
    end
    wr(OFS_CTRL, 32'h0000_0000);
    for (int c = 7; c > 0; c--) probe(3, 32'(c) << 5 | 32'(c[0]) << 4, LOW_LIM[c], 1, c[0]);
    for (int c = 0; c < 7; c++) probe(4, 32'(c) << 1 | 32'(c[0]), 12'(600 + 50 * c), 1, c[0]);
    tally_and_finish();
  end
endmodule : tb_top
bind mfc2_top mfc2_sva #(.RETRY_CYCLES(RETRY_CYCLES)) i_mfc2_sva (.*);
